/* rtl/nvram_cmd_port.sv */
// spi slave command front end of a 2K x 8 serial nvram
// assumes spi pins arrive asynchronously and are oversampled by clock;
// memory array sits outside: writes leave through a fifo, reads by address
`timescale 1ns/1ps
module nvram_cmd_port
  import nvram_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  output wire logic              so,
  output wire logic              so_oe,
  input  wire logic              wp_n,
  output wire logic              mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output wire logic [ADDR_W-1:0] mem_wr_addr,
  output wire logic [7:0]        mem_wr_data,
  output wire logic [ADDR_W-1:0] mem_rd_addr,
  input  wire logic [7:0]        mem_rd_data,
  output wire logic [7:0]        status_byte,
  output wire logic              mode3_active
);

  typedef struct packed {
    logic [1:0]        cs_s;
    logic [1:0]        sck_s;
    logic [1:0]        si_s;
    logic [1:0]        wp_s;
    logic              cs_d;
    logic              sck_d;
    phase_type         phase;
    logic [7:0]        cmd;
    logic [7:0]        in_sh;
    logic [2:0]        bit_cnt;
    logic              addr_hi;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        out_sh;
    logic              so;
    logic              armed;
    logic              mode3;
    logic              wen;
    logic              pin_en;
    logic              bp_hi;
    logic              bp_lo;
    logic              halted;
    logic              push;
    logic [WORD_W-1:0] push_word;
  } port_state_type;

  port_state_type r_r;
  port_state_type r_nxt;
  logic           cs_fall;
  logic           cs_rise;
  logic           sck_rise;
  logic           sck_fall;
  logic           selected;
  logic           byte_end;
  logic [7:0]     shifted;
  logic [7:0]     out_src;
  logic           out_phase;
  logic           wq_ready;

  stream_if #(.W(WORD_W)) wq_in ();
  stream_if #(.W(WORD_W)) wq_out ();

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // status image; unused bits are constant zero
  function automatic logic [7:0] status_of(input port_state_type s);
    logic [7:0] b;
    b             = 8'h00;
    b[SR_PIN_EN]  = s.pin_en;
    b[SR_BP_HI]   = s.bp_hi;
    b[SR_BP_LO]   = s.bp_lo;
    b[SR_WEN]     = s.wen;
    return b;
  endfunction

  // block protect decode, also used by the checks below
  function automatic logic is_protected(input logic hi, input logic lo, input logic [ADDR_W-1:0] a);
    logic p;
    p = 1'b0;
    unique case ({hi, lo})
      2'b00: p = 1'b0;
      2'b01: p = (a >= QUARTER_BASE);
      2'b10: p = (a >= HALF_BASE);
      2'b11: p = 1'b1;
    endcase
    return p;
  endfunction

  function automatic logic is_known_op(input logic [7:0] op);
    return (op == OP_SET_WEN) || (op == OP_CLR_WEN) || (op == OP_RD_STATUS) ||
           (op == OP_WR_STATUS) || (op == OP_RD_MEM) || (op == OP_WR_MEM);
  endfunction

  // ----------------------------------------
  // edges of the synchronised pins
  // ----------------------------------------
  // only the second sync stage is looked at; first stage feeds it alone
  // limitation: output lags a pin fall by up to three clocks, so halves need four
  assign cs_fall   = r_r.cs_d && !r_r.cs_s[1];
  assign cs_rise   = !r_r.cs_d && r_r.cs_s[1];
  assign sck_rise  = r_r.sck_s[1] && !r_r.sck_d;
  assign sck_fall  = !r_r.sck_s[1] && r_r.sck_d;
  assign selected  = !r_r.cs_s[1] && (r_r.phase != PH_IDLE);
  assign shifted   = {r_r.in_sh[6:0], r_r.si_s[1]};
  assign byte_end  = selected && sck_rise && r_r.armed && (r_r.phase != PH_DISCARD) &&
                     (r_r.bit_cnt == LAST_BIT);
  assign out_phase = (r_r.phase == PH_RD_DATA) || (r_r.phase == PH_ST_OUT);
  assign out_src   = (r_r.phase == PH_RD_DATA) ? mem_rd_data : status_of(r_r);

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  // one pass per system clock; the serial clock only shows up as edges
  always_comb begin
    r_nxt       = r_r;
    r_nxt.cs_s  = {r_r.cs_s[0], cs_n};
    r_nxt.sck_s = {r_r.sck_s[0], sck};
    r_nxt.si_s  = {r_r.si_s[0], si};
    r_nxt.wp_s  = {r_r.wp_s[0], wp_n};
    r_nxt.cs_d  = r_r.cs_s[1];
    r_nxt.sck_d = r_r.sck_s[1];
    r_nxt.push  = 1'b0;
    if (cs_rise) begin
      // latch drops only once the command is framed by deselect
      if ((r_r.cmd == OP_CLR_WEN) || (r_r.cmd == OP_WR_STATUS) || (r_r.cmd == OP_WR_MEM)) begin
        r_nxt.wen = 1'b0;
      end
      r_nxt.phase = PH_IDLE;
    end else if (cs_fall) begin
      r_nxt.phase   = PH_OPCODE;
      r_nxt.mode3   = r_r.sck_s[1];
      r_nxt.armed   = !r_r.sck_s[1];
      r_nxt.cmd     = 8'h00;
      r_nxt.bit_cnt = 3'h0;
      r_nxt.addr_hi = 1'b0;
      r_nxt.halted  = 1'b0;
      r_nxt.so      = 1'b0;
    end else if (selected) begin
      if (sck_fall) begin
        r_nxt.armed = 1'b1;
        if (out_phase) begin
          // fresh byte on the first falling edge of each output byte
          if (r_r.bit_cnt == 3'h0) begin
            r_nxt.so     = out_src[7];
            r_nxt.out_sh = {out_src[6:0], 1'b0};
          end else begin
            r_nxt.so     = r_r.out_sh[7];
            r_nxt.out_sh = {r_r.out_sh[6:0], 1'b0};
          end
        end
      end
      if (sck_rise && r_r.armed && (r_r.phase != PH_DISCARD)) begin
        r_nxt.in_sh   = shifted;
        r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
      end
      if (byte_end) begin
        unique case (r_r.phase)
          PH_OPCODE: begin
            if (is_known_op(shifted)) begin
              r_nxt.cmd = shifted;
            end
            if (shifted == OP_SET_WEN) begin
              r_nxt.wen   = 1'b1;
              r_nxt.phase = PH_DISCARD;
            end else if (shifted == OP_CLR_WEN) begin
              r_nxt.phase = PH_DISCARD;
            end else if (shifted == OP_RD_STATUS) begin
              r_nxt.phase = PH_ST_OUT;
            end else if (shifted == OP_WR_STATUS) begin
              r_nxt.phase = PH_ST_IN;
            end else if ((shifted == OP_RD_MEM) || (shifted == OP_WR_MEM)) begin
              r_nxt.phase = PH_ADDR;
            end else begin
              r_nxt.phase = PH_DISCARD;
            end
          end
          PH_ADDR: begin
            // top five bits of the high byte are dropped
            if (!r_r.addr_hi) begin
              r_nxt.addr[ADDR_W-1:8] = shifted[ADDR_W-9:0];
              r_nxt.addr_hi          = 1'b1;
            end else begin
              r_nxt.addr[7:0] = shifted;
              r_nxt.phase     = (r_r.cmd == OP_RD_MEM) ? PH_RD_DATA : PH_WR_DATA;
            end
          end
          PH_WR_DATA: begin
            // a byte that meets a protected block, a clear latch or a full
            // fifo stops the burst; later bytes are dropped silently
            if (r_r.wen && !r_r.halted && wq_ready &&
                !is_protected(r_r.bp_hi, r_r.bp_lo, r_r.addr)) begin
              r_nxt.push      = 1'b1;
              r_nxt.push_word = {r_r.addr, shifted};
              r_nxt.addr      = r_r.addr + 1'b1;
            end else begin
              r_nxt.halted = 1'b1;
            end
          end
          PH_RD_DATA: begin
            r_nxt.addr = r_r.addr + 1'b1;
          end
          PH_ST_IN: begin
            // pin protects the status only when its enable is set
            if (r_r.wen && !(r_r.pin_en && !r_r.wp_s[1])) begin
              r_nxt.pin_en = shifted[SR_PIN_EN];
              r_nxt.bp_hi  = shifted[SR_BP_HI];
              r_nxt.bp_lo  = shifted[SR_BP_LO];
            end
            r_nxt.phase = PH_DISCARD;
          end
          PH_ST_OUT: begin
            r_nxt.phase = PH_ST_OUT;
          end
          default: begin
            r_nxt.phase = PH_DISCARD;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // deselected sync levels at reset so no false select edge appears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r_r        <= '0;
      r_r.cs_s   <= 2'b11;
      r_r.cs_d   <= 1'b1;
      r_r.phase  <= PH_IDLE;
      r_r.wen    <= WEN_RESET;
      r_r.pin_en <= PROT_RESET;
      r_r.bp_hi  <= PROT_RESET;
      r_r.bp_lo  <= PROT_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------
  // write fifo and outputs
  // ----------------------------------------
  assign wq_in.valid  = r_r.push;
  assign wq_in.data   = r_r.push_word;
  assign wq_ready     = wq_in.ready;
  assign mem_wr_valid = wq_out.valid;
  assign wq_out.ready = mem_wr_ready;
  assign mem_wr_addr  = wq_out.data[WORD_W-1:8];
  assign mem_wr_data  = wq_out.data[7:0];

  word_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) u_write_fifo (
    .clock (clock),
    .rst   (rst),
    .in_s  (wq_in),
    .out_s (wq_out)
  );

  // pin released outside read phases and whenever deselected
  assign so           = r_r.so;
  assign so_oe        = out_phase && !r_r.cs_s[1];
  assign mem_rd_addr  = r_r.addr;
  assign status_byte  = status_of(r_r);
  assign mode3_active = r_r.mode3;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_wen_set_cmd: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_OPCODE) && (shifted == OP_SET_WEN) |=> status_byte[SR_WEN])
    else $error("set write enable did not set flag");
  a_wen_clear_end: assert property (@(posedge clock) disable iff (rst)
    cs_rise && ((r_r.cmd == OP_CLR_WEN) || (r_r.cmd == OP_WR_MEM)) |=> !r_r.wen [*2])
    else $error("flag not cleared at deselect");
  a_bad_op_discard: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_OPCODE) && !is_known_op(shifted) |=> (r_r.phase == PH_DISCARD))
    else $error("unknown opcode not discarded");
  a_discard_quiet: assert property (@(posedge clock) disable iff (rst)
    (r_r.phase == PH_DISCARD) || (r_r.phase == PH_IDLE) |-> !so_oe)
    else $error("output driven outside read phase");
  a_deselect_release: assert property (@(posedge clock) disable iff (rst)
    cs_rise |=> !so_oe ##1 !so_oe)
    else $error("output not released after deselect");
  a_mode_capture: assert property (@(posedge clock) disable iff (rst)
    cs_fall |=> (mode3_active == $past(r_r.sck_s[1])))
    else $error("mode not taken from clock level");
  a_addr_low_take: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_ADDR) && r_r.addr_hi |=> (mem_rd_addr[7:0] == $past(shifted)))
    else $error("low address byte not taken");
  a_burst_wrap: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_RD_DATA) |=> (mem_rd_addr == $past(r_r.addr) + 1'b1))
    else $error("read burst address did not step");
  a_push_needs_wen: assert property (@(posedge clock) disable iff (rst)
    r_r.push |-> r_r.wen && !is_protected(r_r.bp_hi, r_r.bp_lo, r_r.push_word[WORD_W-1:8]))
    else $error("write pushed without enable or into protected block");
  a_msb_lead: assert property (@(posedge clock) disable iff (rst)
    selected && sck_fall && out_phase && (r_r.bit_cnt == 3'h0) |=> (so == $past(out_src[7])))
    else $error("output byte not led by msb");
  a_status_zeros: assert property (@(posedge clock) disable iff (rst)
    (status_byte[6:4] == 3'h0) && !status_byte[0])
    else $error("fixed status bits not zero");

  // framing and write-path checks; each one is reached by the bench scenarios
  a_opcode_first: assert property (@(posedge clock) disable iff (rst)
    cs_fall |=> (r_r.phase == PH_OPCODE) && (r_r.bit_cnt == 3'h0))
    else $error("select did not start an opcode byte");
  a_addr_high_take: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_ADDR) && !r_r.addr_hi |=>
    (mem_rd_addr[ADDR_W-1:8] == $past(shifted[ADDR_W-9:0])))
    else $error("high address bits not taken");
  a_status_read_go: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_OPCODE) && (shifted == OP_RD_STATUS) |=> (r_r.phase == PH_ST_OUT))
    else $error("status read did not enter output phase");
  a_status_keeps_wen: assert property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_ST_IN) |=> (r_r.wen == $past(r_r.wen)))
    else $error("status write changed the flag");
  a_status_wr_clear: assert property (@(posedge clock) disable iff (rst)
    cs_rise && (r_r.cmd == OP_WR_STATUS) |=> !status_byte[SR_WEN])
    else $error("flag not cleared after status write");
  a_discard_no_count: assert property (@(posedge clock) disable iff (rst)
    (r_r.phase == PH_DISCARD) && sck_rise |=> (r_r.bit_cnt == $past(r_r.bit_cnt)))
    else $error("input counted after discard");
  // a halted burst must neither write nor move its address
  a_halt_holds: assert property (@(posedge clock) disable iff (rst)
    r_r.halted && (r_r.phase == PH_WR_DATA) |=> !r_r.push && $stable(r_r.addr))
    else $error("halted burst still advanced");

  c_status_read: cover property (@(posedge clock) disable iff (rst)
    (r_r.phase == PH_ST_OUT) && so_oe && sck_fall);
  c_memory_push: cover property (@(posedge clock) disable iff (rst) r_r.push);
  c_bad_opcode: cover property (@(posedge clock) disable iff (rst)
    byte_end && (r_r.phase == PH_OPCODE) && !is_known_op(shifted));
  c_mode3_select: cover property (@(posedge clock) disable iff (rst) cs_fall && r_r.sck_s[1]);
endmodule

/* rtl/nvram_pkg.sv */
// constants, opcodes and phase codes for the serial nvram command port
// assumes a 100 MHz system clock that oversamples the spi pins
package nvram_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned SCK_MAX_HZ   = 20_000_000;
  localparam int unsigned ADDR_W       = 11;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned WORD_W       = ADDR_W + 8;
  localparam logic [7:0]  OP_SET_WEN   = 8'h06;
  localparam logic [7:0]  OP_CLR_WEN   = 8'h04;
  localparam logic [7:0]  OP_RD_STATUS = 8'h05;
  localparam logic [7:0]  OP_WR_STATUS = 8'h01;
  localparam logic [7:0]  OP_RD_MEM    = 8'h03;
  localparam logic [7:0]  OP_WR_MEM    = 8'h02;
  localparam int unsigned SR_PIN_EN    = 7;
  localparam int unsigned SR_BP_HI     = 3;
  localparam int unsigned SR_BP_LO     = 2;
  localparam int unsigned SR_WEN       = 1;
  localparam logic        PROT_RESET   = 1'b0;
  localparam logic        WEN_RESET    = 1'b0;
  localparam logic [10:0] QUARTER_BASE = 11'h600;
  localparam logic [10:0] HALF_BASE    = 11'h400;
  localparam logic [2:0]  LAST_BIT     = 3'h7;

  typedef enum logic [7:0] {
    PH_IDLE    = 8'h01,
    PH_OPCODE  = 8'h02,
    PH_ADDR    = 8'h04,
    PH_WR_DATA = 8'h08,
    PH_RD_DATA = 8'h10,
    PH_ST_OUT  = 8'h20,
    PH_ST_IN   = 8'h40,
    PH_DISCARD = 8'h80
  } phase_type;
endpackage

/* rtl/stream_if.sv */
// valid/ready word stream between the command port and its write fifo
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
interface stream_if #(parameter int W = 19) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* rtl/word_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes depth is a power of two so pointers wrap on their own
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  stream_if.snk    in_s,
  stream_if.src    out_s
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } fifo_state_type;

  fifo_state_type r_r;
  fifo_state_type r_nxt;
  logic           push;
  logic           pop;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign in_s.ready  = (r_r.cnt != (PW+1)'(DEPTH));
  assign out_s.valid = (r_r.cnt != '0);
  assign out_s.data  = r_r.mem[r_r.rp];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // next state: write slot, advance pointers, track fill
  always_comb begin
    r_nxt = r_r;
    if (push) begin
      r_nxt.mem[r_r.wp] = in_s.data;
      r_nxt.wp          = r_r.wp + 1'b1;
    end
    if (pop) begin
      r_nxt.rp = r_r.rp + 1'b1;
    end
    r_nxt.cnt = r_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  a_fifo_fill_bound: assert property (@(posedge clock) disable iff (rst)
    r_r.cnt <= (PW+1)'(DEPTH)) else $error("fifo count beyond depth");
  a_fifo_count_step: assert property (@(posedge clock) disable iff (rst)
    (push && !pop) |=> r_r.cnt == $past(r_r.cnt) + 1'b1) else $error("fifo count did not rise");
endmodule

/* verification/spi_master_model.sv */
// spi master model: drives select, serial clock and data in, reads data out
// assumes the bench clock; pins change only just after its rising edge
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic clock,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  // ----------------------------------------
  // link timing
  // ----------------------------------------
  // 125 ns serial clock on average: high halves alternate six and seven clocks
  localparam int HALF = 6;
  logic idle_lvl;

  // deselected, clock parked low, data line at a defined level
  initial begin
    cs_n     = 1'b1;
    sck      = 1'b0;
    si       = 1'b0;
    idle_lvl = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // ----------------------------------------
  // frame tasks
  // ----------------------------------------
  // park the clock at the mode's idle level, then select
  task automatic start(input logic mode3);
    idle_lvl = mode3;
    sck <= mode3;
    wait_clk(HALF);
    cs_n <= 1'b0;
    wait_clk(HALF);
  endtask

  // one byte msb first; data out read at the rising edge, data in set on the low half
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= tx[i];
      wait_clk(HALF);
      rx[i] = so;
      sck <= 1'b1;
      wait_clk(HALF + (i % 2));
    end
  endtask

  // back to idle level, deselect; released data line shows the inverse level
  task automatic stop();
    sck <= idle_lvl;
    wait_clk(HALF);
    cs_n <= 1'b1;
    si   <= ~si;
    wait_clk(2 * HALF);
  endtask
endmodule

/* verification/nvram_cmd_port_tb.sv */
// self-checking bench for the serial nvram command port
// assumes the spi master model on the pins; the memory array is modelled here
`timescale 1ns/1ps
module nvram_cmd_port_tb;
  import nvram_pkg::*;
  logic              clock;
  logic              rst;
  logic              wp_n;
  logic              mem_wr_ready;
  logic [7:0]        mem_rd_data;
  logic [7:0]        rx;
  logic [7:0]        mem [0:2047];
  logic [18:0]       got [$];
  int                err_count;
  int                checks;
  wire logic         cs_n;
  wire logic         sck;
  wire logic         si;
  wire logic         so;
  wire logic         so_oe;
  wire logic         mem_wr_valid;
  wire logic [10:0]  mem_wr_addr;
  wire logic [7:0]   mem_wr_data;
  wire logic [10:0]  mem_rd_addr;
  wire logic [7:0]   status_byte;
  wire logic         mode3_active;

  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  spi_master_model i_master (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so));

  nvram_cmd_port #(.DEPTH(8)) i_dut (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .wp_n(wp_n), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .status_byte(status_byte), .mode3_active(mode3_active));

  // memory array: registered read well inside the two-clock allowance; pops logged
  always @(posedge clock) begin
    mem_rd_data <= mem[mem_rd_addr];
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      mem[mem_wr_addr] <= mem_wr_data;
      got.push_back({mem_wr_addr, mem_wr_data});
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic cmd(input logic mode3, input logic [7:0] op);
    i_master.start(mode3);
    i_master.xfer(op, rx);
    i_master.stop();
  endtask

  task automatic wr_status(input logic [7:0] v);
    i_master.start(1'b0);
    i_master.xfer(OP_WR_STATUS, rx);
    i_master.xfer(v, rx);
    i_master.stop();
  endtask

  // opcode, two address bytes, then n data bytes counting up from d0
  task automatic mem_write(input logic mode3, input logic [15:0] addr, input logic [7:0] d0, input int n);
    i_master.start(mode3);
    i_master.xfer(OP_WR_MEM, rx);
    check(mode3_active, mode3, "mode at select");
    i_master.xfer(addr[15:8], rx);
    i_master.xfer(addr[7:0], rx);
    for (int i = 0; i < n; i++) begin
      i_master.xfer(d0 + 8'(i), rx);
    end
    i_master.stop();
    repeat (20) @(posedge clock);
  endtask

  // compare the words handed to the array, then forget them
  task automatic check_words(input int n, input logic [10:0] a0, input logic [7:0] d0);
    check(got.size(), n, "word count");
    for (int i = 0; i < n && i < got.size(); i++) begin
      check(got[i], {a0 + 11'(i), d0 + 8'(i)}, "word");
    end
    got.delete();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(status_byte, 8'h00, "status after reset");
    check({so_oe, mem_wr_valid, mode3_active}, 3'h0, "outputs after reset");
    $display("test reset finished");
  endtask

  task automatic t_latch();
    cmd(1'b0, OP_SET_WEN);
    check(status_byte, 8'h02, "flag after set");
    i_master.start(1'b0);
    i_master.xfer(OP_RD_STATUS, rx);
    i_master.xfer(8'h00, rx);
    check(so_oe, 1'b1, "drive in status read");
    i_master.stop();
    check(rx, 8'h02, "status read");
    cmd(1'b1, OP_CLR_WEN);
    check(status_byte, 8'h00, "flag after clear");
    $display("test latch finished");
  endtask

  task automatic t_status();
    wr_status(8'hFF);
    check(status_byte, 8'h00, "status write while disabled");
    cmd(1'b0, OP_SET_WEN);
    wr_status(8'hFF);
    check(status_byte, 8'h8C, "status write");
    wp_n <= 1'b0;
    cmd(1'b0, OP_SET_WEN);
    wr_status(8'h00);
    check(status_byte, 8'h8C, "status write with pin low");
    wp_n <= 1'b1;
    cmd(1'b0, OP_SET_WEN);
    wr_status(8'h04);
    check(status_byte, 8'h04, "upper quarter protected");
    $display("test status finished");
  endtask

  task automatic t_protect();
    cmd(1'b0, OP_SET_WEN);
    mem_write(1'b0, 16'h05FF, 8'h11, 2);
    check_words(1, 11'h5FF, 8'h11);
    // upper half protected: the first byte below 400h lands, the next halts
    cmd(1'b0, OP_SET_WEN);
    wr_status(8'h08);
    check(status_byte, 8'h08, "upper half protected");
    cmd(1'b0, OP_SET_WEN);
    mem_write(1'b0, 16'h03FF, 8'h21, 2);
    check_words(1, 11'h3FF, 8'h21);
    // whole array protected: nothing lands
    cmd(1'b0, OP_SET_WEN);
    wr_status(8'h0C);
    check(status_byte, 8'h0C, "all protected");
    cmd(1'b0, OP_SET_WEN);
    mem_write(1'b0, 16'h0000, 8'h31, 1);
    check_words(0, 11'h000, 8'h31);
    cmd(1'b0, OP_SET_WEN);
    wr_status(8'h00);
    check(status_byte, 8'h00, "protection off");
    $display("test protect finished");
  endtask

  task automatic t_wrap();
    cmd(1'b1, OP_SET_WEN);
    mem_write(1'b1, 16'hFFFF, 8'hA1, 2);
    check_words(2, 11'h7FF, 8'hA1);
    check(status_byte, 8'h00, "flag after write");
    $display("test wrap finished");
  endtask

  // array stalls: eight words fit, the ninth halts the burst
  task automatic t_fifo();
    mem_wr_ready <= 1'b0;
    cmd(1'b0, OP_SET_WEN);
    mem_write(1'b0, 16'h0010, 8'h30, 10);
    check(mem_wr_valid, 1'b1, "words waiting");
    repeat (40) begin
      @(posedge clock);
      mem_wr_ready <= ~mem_wr_ready;
    end
    mem_wr_ready <= 1'b1;
    repeat (4) @(posedge clock);
    check_words(8, 11'h010, 8'h30);
    check(mem_wr_valid, 1'b0, "drained");
    $display("test fifo finished");
  endtask

  task automatic t_read();
    logic [7:0] a;
    logic [7:0] b;
    i_master.start(1'b0);
    i_master.xfer(OP_RD_MEM, rx);
    i_master.xfer(8'h07, rx);
    i_master.xfer(8'hFF, rx);
    i_master.xfer(8'h00, a);
    check(so_oe, 1'b1, "drive in read");
    i_master.xfer(8'h00, b);
    i_master.stop();
    check(a, 8'hA1, "read top byte");
    check(b, 8'hA2, "read after wrap");
    check(so_oe, 1'b0, "released after read");
    $display("test read finished");
  endtask

  task automatic t_invalid();
    i_master.start(1'b0);
    i_master.xfer(8'hFF, rx);
    i_master.xfer(OP_SET_WEN, rx);
    check(so_oe, 1'b0, "released after bad opcode");
    i_master.stop();
    check(status_byte, 8'h00, "later bytes ignored");
    i_master.xfer(OP_SET_WEN, rx);
    repeat (12) @(posedge clock);
    check({so_oe, status_byte}, 9'h000, "ignored while deselected");
    $display("test invalid finished");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run is some 7900 clocks; six times that means a hang
  initial begin
    repeat (50000) @(posedge clock);
    err_count++;
    print_verdict();
  end

  initial begin
    rst          = 1'b1;
    wp_n         = 1'b1;
    mem_wr_ready = 1'b1;
    err_count    = 0;
    checks       = 0;
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'h00;
    end
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    // sync flops fill before the first select
    repeat (5) @(posedge clock);
    t_reset();
    t_latch();
    t_status();
    t_protect();
    t_wrap();
    t_fifo();
    t_read();
    t_invalid();
    print_verdict();
  end
endmodule
